/* File: include/rx_filter_defines.svh */
// register offsets, field positions, reset values and frame constants of the receive filter
`ifndef RX_FILTER_DEFINES_SVH
`define RX_FILTER_DEFINES_SVH

`define REG_CTRL0 5'h00
`define REG_CTRL1 5'h01
`define REG_ACK_CTRL2 5'h02
`define REG_STATUS 5'h03
`define REG_DATA 5'h04
`define REG_SHORT0 5'h08
`define REG_SHORT1 5'h09
`define REG_PAN0 5'h0A
`define REG_PAN1 5'h0B
`define REG_EXT_BASE 5'h10
`define REG_EXT_LAST 5'h17

`define BIT_SLOTTED 0
`define BIT_FLUSH 1
`define BIT_ACK_TRIG 2
`define BIT_PROTECT 7
`define BIT_PROMISC 1
`define BIT_UPLOAD 4
`define BIT_FILTER 5
`define BIT_COORD 3
`define BIT_ACK_SUPPRESS 4
`define FVN_HI 7
`define FVN_LO 6
`define STAT_NONEMPTY 0
`define STAT_ACK_PEND 1
`define STAT_LOCK 2
`define STAT_FCS 7

`define RST_SHORT 16'hFFFF
`define RST_PAN 16'hFFFF
`define RST_EXT 64'h0000000000000000
`define RST_FVN 2'h1

`define FT_BEACON 3'h0
`define FT_DATA 3'h1
`define FT_ACK 3'h2
`define FT_CMD 3'h3
`define AM_NONE 2'h0
`define AM_SHORT 2'h2
`define AM_EXT 2'h3
`define BCAST 16'hFFFF
`define HDR_MAX 23
`define FIFO_DEPTH 32

`endif

/* File: include/rx_filter_pkg.sv */
// types shared by the receive filter and its testbench
package rx_filter_pkg;

	typedef struct packed {
		logic [1:0] fvn;
		logic ack_suppress;
		logic coord;
		logic filter;
		logic upload;
		logic promisc;
		logic protect;
		logic slotted;
	} cfg_t;

	typedef struct packed {
		logic [1:0] src_mode;
		logic [1:0] version;
		logic [1:0] dst_mode;
		logic [2:0] rsv;
		logic pan_compress;
		logic ack_request;
		logic pending;
		logic security;
		logic [2:0] ftype;
	} frame_ctrl_t;

	typedef struct packed {
		logic rx_begin;
		logic rx_done;
		logic addr_match;
	} irq_t;

	typedef enum logic [1:0] {
		ST_LISTEN = 2'b01,
		ST_BUSY = 2'b10
	} rx_state_t;

endpackage : rx_filter_pkg

/* File: logic/byte_fifo.sv */
// frame byte fifo with registered read data
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic ov_q;
	logic [WIDTH-1:0] od_q;
	logic we;
	logic load;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign we = in_valid && in_ready;
	// output stage refills whenever it is free or being taken
	assign load = (cnt_q != '0) && (!ov_q || out_ready);
	assign out_valid = ov_q;
	assign out_data = od_q;
	assign empty = !ov_q && (cnt_q == '0);

	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (we) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (load) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + {{AW{1'b0}}, we} - {{AW{1'b0}}, load};
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ov_q <= 1'b0;
			od_q <= '0;
		end else if (flush) begin
			ov_q <= 1'b0;
		end else if (load) begin
			ov_q <= 1'b1;
			od_q <= mem[rd_q];
		end else if (out_ready) begin
			ov_q <= 1'b0;
		end
	end

endmodule : byte_fifo

/* File: logic/rx_frame_filter.sv */
// receive frame acceptance, address match and auto-acknowledge decision
// Summary of operation
// RULE1 - promiscuous mode passes every frame on without address-based acceptance
// RULE2 - promiscuous mode raises receive-done at every frame end, even with bad FCS
// RULE3 - software reads the FCS-valid flag after receive-done and drops bad frames
// RULE4 - software sets ack suppression for promiscuous operation, else matches get acked
// RULE5 - address-match is raised in every mode when the filter matches the node
// RULE6 - a valid PHY header while listening raises receive-start and begins reception
// RULE7 - the FCS-valid flag is updated in the same cycle as receive-done
// RULE8 - software writes all address bytes to 0x00 for promiscuous mode
// RULE9 - sniffer setup gives receive-start, receive-done and FCS flag for every frame
// RULE10 - frame-version policy 7:6 acks versions up to 0, 1, 2 or all
// RULE11 - upload without filter: intact reserved frames done, never matched, never acked
// RULE12 - upload with filter: reserved frames filtered like data frames
// RULE13 - under reserved filtering ack only if requested and receive-done was raised
// RULE14 - software never sets reserved filtering without reserved upload
// RULE15 - protect bit 7 keeps a received frame from being overwritten
// RULE16 - slotted bit 0 selects unslotted or software-triggered slotted acknowledge
// RULE17 - coordinator bit 3 admits source-only addressed data and command frames
// RULE18 - no address-match when destination mode is 0 or 1 and source mode is 0
// RULE19 - unassigned frame type codes take the reserved-type handling path
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "rx_filter_defines.svh"
module rx_frame_filter #(
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic rx_phr_valid,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	output logic rx_byte_ready,
	input wire logic rx_end,
	input wire logic rx_fcs_ok,
	output rx_filter_pkg::irq_t irq,
	output logic ack_tx_start,
	output logic ack_slotted
);
	localparam int HDR = `HDR_MAX;

	rx_filter_pkg::cfg_t cfg_q;
	rx_filter_pkg::rx_state_t state_q;
	rx_filter_pkg::frame_ctrl_t fcf;
	rx_filter_pkg::irq_t irq_q;
	logic [15:0] short_q;
	logic [15:0] pan_q;
	logic [7:0] ext_q [0:7];
	logic [7:0] hdr_q [0:HDR-1];
	logic [6:0] idx_q;
	logic ami_fired_q;
	logic match_q;
	logic fcs_valid_q;
	logic lock_q;
	logic ack_pend_q;
	logic ack_start_q;
	logic [7:0] rdata_q;
	logic flush_cmd;
	logic trig_cmd;
	logic fifo_flush;
	logic fifo_in_valid;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [7:0] fifo_data;
	logic fifo_empty;
	logic busy;
	logic frame_end;
	logic [4:0] dpan_len;
	logic [4:0] dadr_len;
	logic [4:0] span_len;
	logic [4:0] sadr_len;
	logic [4:0] o_dadr;
	logic [4:0] o_span;
	logic [4:0] o_sadr;
	logic [4:0] hdr_len;
	logic [15:0] dpan;
	logic [15:0] dshort;
	logic [15:0] span;
	logic ext_eq;
	logic type_res;
	logic ver_ok;
	logic pan_ok;
	logic dadr_ok;
	logic beacon_ok;
	logic src_only_ok;
	logic match;
	logic ami_allowed;
	logic hdr_done;
	logic match_now;
	logic done;
	logic ack_want;

	assign fcf = rx_filter_pkg::frame_ctrl_t'({hdr_q[1], hdr_q[0]});
	assign busy = (state_q == rx_filter_pkg::ST_BUSY);
	assign frame_end = busy && rx_end;
	assign flush_cmd = reg_wr && (reg_addr == `REG_CTRL0) && reg_wdata[`BIT_FLUSH];
	assign trig_cmd = reg_wr && (reg_addr == `REG_CTRL0) && reg_wdata[`BIT_ACK_TRIG];

	// ---------------- configuration registers ----------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= '0;
			cfg_q.fvn <= `RST_FVN;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`REG_CTRL0: begin
					cfg_q.slotted <= reg_wdata[`BIT_SLOTTED]; // [RULE16]
					cfg_q.protect <= reg_wdata[`BIT_PROTECT]; // [RULE15]
				end
				`REG_CTRL1: begin
					cfg_q.promisc <= reg_wdata[`BIT_PROMISC];
					cfg_q.upload <= reg_wdata[`BIT_UPLOAD];
					cfg_q.filter <= reg_wdata[`BIT_FILTER];
				end
				`REG_ACK_CTRL2: begin
					cfg_q.coord <= reg_wdata[`BIT_COORD]; // [RULE17]
					cfg_q.ack_suppress <= reg_wdata[`BIT_ACK_SUPPRESS];
					cfg_q.fvn <= reg_wdata[`FVN_HI:`FVN_LO]; // [RULE10]
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			short_q <= `RST_SHORT;
			pan_q <= `RST_PAN;
		end else if (reg_wr) begin
			if (reg_addr == `REG_SHORT0) short_q[7:0] <= reg_wdata;
			if (reg_addr == `REG_SHORT1) short_q[15:8] <= reg_wdata;
			if (reg_addr == `REG_PAN0) pan_q[7:0] <= reg_wdata;
			if (reg_addr == `REG_PAN1) pan_q[15:8] <= reg_wdata;
		end
	end

	for (genvar g = 0; g < 8; g++) begin : g_ext
		always_ff @(posedge sys_clk or negedge nrst) begin
			if (!nrst) begin
				ext_q[g] <= 8'(`RST_EXT >> (8 * g));
			end else if (reg_wr && (reg_addr == `REG_EXT_BASE + 5'(g))) begin
				ext_q[g] <= reg_wdata;
			end
		end
	end

	// ---------------- receive sequencing ----------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= rx_filter_pkg::ST_LISTEN;
		end else begin
			unique case (state_q)
				rx_filter_pkg::ST_LISTEN: begin
					if (rx_phr_valid) state_q <= rx_filter_pkg::ST_BUSY; // [RULE6]
				end
				rx_filter_pkg::ST_BUSY: begin
					if (rx_end) state_q <= rx_filter_pkg::ST_LISTEN;
				end
				default: state_q <= rx_filter_pkg::ST_LISTEN;
			endcase
		end
	end

	// header bytes kept for address evaluation; payload only counted
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			idx_q <= '0;
			for (int i = 0; i < HDR; i++) hdr_q[i] <= 8'h00;
		end else if (!busy && rx_phr_valid) begin
			idx_q <= '0;
			for (int i = 0; i < HDR; i++) hdr_q[i] <= 8'h00;
		end else if (busy && rx_byte_valid) begin
			if (idx_q < 7'(HDR)) hdr_q[idx_q[4:0]] <= rx_byte;
			if (idx_q != 7'h7F) idx_q <= idx_q + 7'h01;
		end
	end

	// ---------------- third level address filter ----------------
	always_comb begin
		dpan_len = fcf.dst_mode[1] ? 5'h02 : 5'h00;
		dadr_len = (fcf.dst_mode == `AM_SHORT) ? 5'h02 : (fcf.dst_mode == `AM_EXT) ? 5'h08 : 5'h00;
		span_len = (fcf.src_mode[1] && !(fcf.pan_compress && fcf.dst_mode[1])) ? 5'h02 : 5'h00;
		sadr_len = (fcf.src_mode == `AM_SHORT) ? 5'h02 : (fcf.src_mode == `AM_EXT) ? 5'h08 : 5'h00;
		o_dadr = 5'h03 + dpan_len;
		o_span = o_dadr + dadr_len;
		o_sadr = o_span + span_len;
		hdr_len = o_sadr + sadr_len;
		dpan = {hdr_q[4], hdr_q[3]};
		dshort = {hdr_q[o_dadr + 5'h01], hdr_q[o_dadr]};
		// a compressed source pan is the destination pan
		span = (span_len != 5'h00) ? {hdr_q[o_span + 5'h01], hdr_q[o_span]} : dpan;
		ext_eq = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (hdr_q[o_dadr + 5'(i)] != ext_q[i]) ext_eq = 1'b0;
		end
	end

	always_comb begin
		type_res = (fcf.ftype > `FT_CMD); // [RULE19]
		ver_ok = (fcf.version <= cfg_q.fvn) || (cfg_q.fvn == 2'h3); // [RULE10]
		pan_ok = !fcf.dst_mode[1] || (dpan == pan_q) || (dpan == `BCAST);
		unique case (fcf.dst_mode)
			`AM_SHORT: dadr_ok = (dshort == short_q) || (dshort == `BCAST);
			`AM_EXT: dadr_ok = ext_eq;
			default: dadr_ok = 1'b1;
		endcase
		beacon_ok = (fcf.ftype != `FT_BEACON) || (pan_q == `BCAST) || (span == pan_q);
		src_only_ok = 1'b1;
		if ((fcf.dst_mode == `AM_NONE) && (fcf.src_mode != `AM_NONE) && (fcf.ftype != `FT_BEACON)) begin
			src_only_ok = cfg_q.coord && (span == pan_q); // [RULE17]
		end
		// reserved types pass only when filtered like data frames
		match = (!type_res || (cfg_q.upload && cfg_q.filter)) && ver_ok && pan_ok && dadr_ok // [RULE12]
			&& beacon_ok && src_only_ok && (fcf.ftype != `FT_ACK)
			&& ((fcf.dst_mode != `AM_NONE) || (fcf.src_mode != `AM_NONE));
		ami_allowed = !((fcf.dst_mode <= 2'h1) && (fcf.src_mode == `AM_NONE)) // [RULE18]
			&& !(type_res && !cfg_q.filter); // [RULE11]
	end

	assign hdr_done = (idx_q >= 7'h02) && (idx_q >= {2'b00, hdr_len});
	// a frame that ends before its header completes never matches
	assign match_now = ami_fired_q ? match_q : (hdr_done && match);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ami_fired_q <= 1'b0;
			match_q <= 1'b0;
		end else if (!busy) begin
			ami_fired_q <= 1'b0;
			match_q <= 1'b0;
		end else if (hdr_done && !ami_fired_q) begin
			ami_fired_q <= 1'b1;
			match_q <= match;
		end
	end

	// ---------------- end of frame decision ----------------
	always_comb begin
		if (cfg_q.promisc) begin
			done = 1'b1; // [RULE1] [RULE2] [RULE9]
		end else if (type_res && !cfg_q.upload) begin
			done = 1'b0;
		end else if (type_res && !cfg_q.filter) begin
			done = rx_fcs_ok; // [RULE11]
		end else begin
			done = rx_fcs_ok && match_now; // [RULE12]
		end
		// ack only for data and command style frames the filter accepted
		ack_want = frame_end && done && rx_fcs_ok && match_now && fcf.ack_request && ver_ok // [RULE13]
			&& !cfg_q.ack_suppress && (fcf.ftype != `FT_BEACON) && !(type_res && !cfg_q.filter); // [RULE11]
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq_q <= '0;
		end else begin
			irq_q.rx_begin <= !busy && rx_phr_valid; // [RULE6] [RULE9]
			irq_q.addr_match <= busy && hdr_done && !ami_fired_q && match && ami_allowed; // [RULE5]
			irq_q.rx_done <= frame_end && done;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fcs_valid_q <= 1'b0;
		end else if (frame_end && done) begin
			fcs_valid_q <= rx_fcs_ok; // [RULE7]
		end
	end

	// slotted mode holds the ack until software triggers it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ack_pend_q <= 1'b0;
			ack_start_q <= 1'b0;
		end else begin
			ack_start_q <= (ack_want && !cfg_q.slotted) || (trig_cmd && ack_pend_q); // [RULE16]
			if (ack_want && cfg_q.slotted) begin
				ack_pend_q <= 1'b1;
			end else if (trig_cmd || !cfg_q.slotted) begin
				ack_pend_q <= 1'b0;
			end
		end
	end

	// ---------------- frame buffer and protection ----------------
	// set wins: a protected frame completing while software drains stays locked
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			lock_q <= 1'b0;
		end else if (frame_end && done && cfg_q.protect) begin
			lock_q <= 1'b1; // [RULE15]
		end else if (flush_cmd || !cfg_q.protect || (!busy && fifo_empty)) begin
			lock_q <= 1'b0;
		end
	end

	// an unprotected buffer is overwritten by the next frame
	assign fifo_flush = flush_cmd || (!busy && rx_phr_valid && !lock_q); // [RULE15]
	assign fifo_in_valid = busy && rx_byte_valid && !lock_q;
	assign fifo_pop = reg_rd && (reg_addr == `REG_DATA);

	byte_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.flush(fifo_flush),
		.in_valid(fifo_in_valid),
		.in_ready(rx_byte_ready),
		.in_data(rx_byte),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data),
		.empty(fifo_empty)
	);

	// ---------------- register read ----------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			rdata_q <= 8'h00;
			if (reg_addr >= `REG_EXT_BASE && reg_addr <= `REG_EXT_LAST) begin
				rdata_q <= ext_q[reg_addr[2:0]];
			end
			unique case (reg_addr)
				`REG_CTRL0: begin
					rdata_q[`BIT_SLOTTED] <= cfg_q.slotted;
					rdata_q[`BIT_PROTECT] <= cfg_q.protect;
				end
				`REG_CTRL1: begin
					rdata_q[`BIT_PROMISC] <= cfg_q.promisc;
					rdata_q[`BIT_UPLOAD] <= cfg_q.upload;
					rdata_q[`BIT_FILTER] <= cfg_q.filter;
				end
				`REG_ACK_CTRL2: begin
					rdata_q[`BIT_COORD] <= cfg_q.coord;
					rdata_q[`BIT_ACK_SUPPRESS] <= cfg_q.ack_suppress;
					rdata_q[`FVN_HI:`FVN_LO] <= cfg_q.fvn;
				end
				`REG_STATUS: begin
					rdata_q[`STAT_FCS] <= fcs_valid_q; // [RULE3]
					rdata_q[`STAT_NONEMPTY] <= fifo_out_valid;
					rdata_q[`STAT_ACK_PEND] <= ack_pend_q;
					rdata_q[`STAT_LOCK] <= lock_q;
				end
				`REG_DATA: rdata_q <= fifo_out_valid ? fifo_data : 8'h00;
				`REG_SHORT0: rdata_q <= short_q[7:0];
				`REG_SHORT1: rdata_q <= short_q[15:8];
				`REG_PAN0: rdata_q <= pan_q[7:0];
				`REG_PAN1: rdata_q <= pan_q[15:8];
				default: begin
				end
			endcase
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = irq_q;
	assign ack_tx_start = ack_start_q;
	assign ack_slotted = cfg_q.slotted;

endmodule : rx_frame_filter

/* File: testbench/rx_node_model.sv */
// remote node model that sends frames into the receiver
`timescale 1ns/1ps
module rx_node_model (
	input wire logic sys_clk,
	output logic phr,
	output logic bv,
	output logic [7:0] b,
	output logic fin,
	output logic ok
);
	initial begin
		phr = 1'b0;
		bv = 1'b0;
		b = 8'h00;
		fin = 1'b0;
		ok = 1'b0;
	end
	// idle data shows the inverse of the last byte so a stale value never passes for a fresh one
	task send(input logic [7:0] q[$], input logic good);
		@(posedge sys_clk);
		phr <= 1'b1;
		foreach (q[i]) begin
			@(posedge sys_clk);
			phr <= 1'b0;
			bv <= 1'b1;
			b <= q[i];
		end
		@(posedge sys_clk);
		phr <= 1'b0;
		bv <= 1'b0;
		b <= ~b;
		fin <= 1'b1;
		ok <= good;
		@(posedge sys_clk);
		fin <= 1'b0;
		ok <= ~good;
	endtask : send
endmodule : rx_node_model

/* File: testbench/rx_frame_filter_sva.sv */
// port assertions for the receive filter
`timescale 1ns/1ps
module rx_frame_filter_sva #(
	parameter int FIFO_DEPTH = 32
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic rx_phr_valid,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_byte_ready,
	input wire logic rx_end,
	input wire logic rx_fcs_ok,
	input wire rx_filter_pkg::irq_t irq,
	input wire logic ack_tx_start,
	input wire logic ack_slotted
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_begin_cause: assert property (irq.rx_begin |-> $past(rx_phr_valid))
		else $error("rx_begin without header");
	a_done_cause: assert property (irq.rx_done |-> $past(rx_end))
		else $error("rx_done without frame end");
	// the header byte count is registered first, so the flag trails its closing byte by two edges
	a_match_cause: assert property (irq.addr_match |-> $past(rx_byte_valid, 2) && !irq.rx_begin)
		else $error("addr_match not after a byte");
	a_ack_cause: assert property (ack_tx_start |-> $past(rx_end) || $past(reg_wr))
		else $error("ack without cause");
	a_ack_done: assert property (ack_tx_start && !ack_slotted |-> irq.rx_done)
		else $error("unslotted ack without rx_done");
	a_ack_slot_trig: assert property (ack_tx_start && ack_slotted |->
		$past(reg_wr && reg_addr == 5'h00 && reg_wdata[2]))
		else $error("slotted ack without trigger");
	a_slot_level: assert property ($past(reg_wr && reg_addr == 5'h00) |->
		ack_slotted == $past(reg_wdata[0]))
		else $error("ack_slotted not following control bit");
	a_rdata_unmapped: assert property ($past(reg_rd && reg_addr == 5'h05) |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule : rx_frame_filter_sva
bind rx_frame_filter rx_frame_filter_sva #(.FIFO_DEPTH(FIFO_DEPTH)) rx_frame_filter_sva_i (.sys_clk, .nrst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_phr_valid, .rx_byte_valid, .rx_byte,
	.rx_byte_ready, .rx_end, .rx_fcs_ok, .irq, .ack_tx_start, .ack_slotted);

/* File: testbench/test_rx_frame_filter.sv */
// self-checking bench for the receive filter
`timescale 1ns/1ps
module test_rx_frame_filter;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic phr, bv, fin, ok, rdy, ack, slot;
	logic [7:0] b;
	rx_filter_pkg::irq_t irq;
	logic [3:0] seen = 4'h0;
	logic lowrdy = 1'b0;
	int err_count = 0;
	int n_checks = 0;
	always #2 sys_clk = ~sys_clk;
	rx_node_model rx_node_model_i (.sys_clk(sys_clk), .phr(phr), .bv(bv), .b(b), .fin(fin), .ok(ok));
	rx_frame_filter #(.FIFO_DEPTH(32)) rx_frame_filter_i (.sys_clk(sys_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rx_phr_valid(phr), .rx_byte_valid(bv), .rx_byte(b),
		.rx_byte_ready(rdy), .rx_end(fin), .rx_fcs_ok(ok), .irq(irq), .ack_tx_start(ack),
		.ack_slotted(slot));
	// seen = {begin, match, done, ack}, sticky until a scenario clears it
	always @(posedge sys_clk) begin
		if (irq.rx_begin) seen[3] <= 1'b1;
		if (irq.addr_match) seen[2] <= 1'b1;
		if (irq.rx_done) seen[1] <= 1'b1;
		if (ack) seen[0] <= 1'b1;
		if (!rdy) lowrdy <= 1'b1;
	end
	task stop_test;
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rdchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, exp);
	endtask : rdchk
	// short dst, short src, compressed pan 0x1234, one payload byte, two fcs bytes
	task frm(input logic [7:0] f0, input logic [7:0] f1, input logic [15:0] dst, input logic good,
		input logic [3:0] exp);
		logic [7:0] q[$];
		seen = 4'h0;
		q = {f0, f1, 8'h01, 8'h34, 8'h12, dst[7:0], dst[15:8], 8'h22, 8'h11, 8'hAA, 8'h5A, 8'hA5};
		rx_node_model_i.send(q, good);
		repeat (3) @(posedge sys_clk);
		chk({4'h0, seen}, {4'h0, exp});
	endtask : frm
	task t_reset;
		rdchk(5'h02, 8'hFF, 8'h40);
		rdchk(5'h08, 8'hFF, 8'hFF);
		rdchk(5'h10, 8'hFF, 8'h00);
		rdchk(5'h05, 8'hFF, 8'h00);
		wr(5'h0A, 8'h34);
		wr(5'h0B, 8'h12);
	endtask : t_reset
	task t_basic;
		frm(8'h61, 8'h88, 16'hFFFF, 1'b1, 4'hF);
		rdchk(5'h03, 8'h80, 8'h80);
		frm(8'h61, 8'h88, 16'hFFFF, 1'b0, 4'hC);
		rdchk(5'h03, 8'h80, 8'h80);
		frm(8'h61, 8'h88, 16'h5555, 1'b1, 4'h8);
	endtask : t_basic
	task t_promisc;
		wr(5'h02, 8'h50);
		wr(5'h01, 8'h02);
		frm(8'h61, 8'h88, 16'hFFFF, 1'b0, 4'hE);
		rdchk(5'h03, 8'h80, 8'h00);
		frm(8'h61, 8'h88, 16'h5555, 1'b1, 4'hA);
		// destination mode 1, no source: it matches, yet must not announce itself
		frm(8'h61, 8'h04, 16'hFFFF, 1'b1, 4'hA);
		for (int a = 8; a < 12; a++) wr(5'(a), 8'h00);
		frm(8'h61, 8'h88, 16'hFFFF, 1'b1, 4'hA);
		wr(5'h0A, 8'h34);
		wr(5'h0B, 8'h12);
		wr(5'h02, 8'h40);
		frm(8'h61, 8'h88, 16'hFFFF, 1'b1, 4'hF);
		wr(5'h01, 8'h00);
	endtask : t_promisc
	task t_fvn;
		for (int v = 0; v < 4; v++) begin
			wr(5'h02, 8'(v << 6));
			frm(8'h61, 8'hA8, 16'hFFFF, 1'b1, (v >= 2) ? 4'hF : 4'h8);
		end
		wr(5'h02, 8'h40);
	endtask : t_fvn
	task t_reserved;
		wr(5'h01, 8'h10);
		frm(8'h65, 8'h88, 16'hFFFF, 1'b1, 4'hA);
		frm(8'h65, 8'h88, 16'h5555, 1'b0, 4'h8);
		wr(5'h01, 8'h30);
		frm(8'h65, 8'h88, 16'h5555, 1'b1, 4'h8);
		frm(8'h65, 8'h88, 16'hFFFF, 1'b1, 4'hF);
		frm(8'h45, 8'h88, 16'hFFFF, 1'b1, 4'hE);
		wr(5'h01, 8'h00);
	endtask : t_reserved
	task t_slot;
		wr(5'h00, 8'h01);
		#1 chk({7'h00, slot}, 8'h01);
		frm(8'h61, 8'h88, 16'hFFFF, 1'b1, 4'hE);
		rdchk(5'h03, 8'h02, 8'h02);
		seen = 4'h0;
		wr(5'h00, 8'h05);
		repeat (2) @(posedge sys_clk);
		chk({4'h0, seen}, 8'h01);
		wr(5'h00, 8'h00);
	endtask : t_slot
	task t_protect;
		logic [7:0] q[$];
		wr(5'h00, 8'h80);
		frm(8'h61, 8'h88, 16'hFFFF, 1'b1, 4'hF);
		q = {8'h41, 8'h88, 8'h07};
		rx_node_model_i.send(q, 1'b1);
		rdchk(5'h04, 8'hFF, 8'h61);
		rdchk(5'h04, 8'hFF, 8'h88);
		wr(5'h00, 8'h00);
	endtask : t_protect
	task t_fill;
		logic [7:0] q[$];
		for (int i = 0; i < 40; i++) q.push_back(8'(i));
		lowrdy = 1'b0;
		rx_node_model_i.send(q, 1'b1);
		@(posedge sys_clk);
		chk({7'h00, lowrdy}, 8'h01);
		wr(5'h00, 8'h02);
		rdchk(5'h03, 8'h01, 8'h00);
		rdchk(5'h04, 8'hFF, 8'h00);
	endtask : t_fill
	initial begin
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		t_reset();
		t_basic();
		t_promisc();
		t_fvn();
		t_reserved();
		t_slot();
		t_protect();
		t_fill();
		stop_test();
	end
	// the whole sequence takes well under 2000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		stop_test();
	end
endmodule : test_rx_frame_filter
